// ===== rtl/lowspeed_device.sv
/*
 * Module end of the low-speed control link: pin synchronisers, reset
 * pulse qualification and init timing, power mode selection, management
 * byte map, and the open-drain interrupt with its release sequence.
 * Assumes management accesses arrive on clk as one-cycle strobes.
 */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// - answer management accesses while select is low
// - ignore all management traffic while deselected
// - undriven select reads high, deselected
// - host waits de-assert time after deselect
// - host waits assert time after select
// - host may overlap different modules' select waits
// - undriven reset input reads inactive high
// - long reset pulse restores all defaults
// - init interval starts at reset rising edge
// - host ignores status until reset completion
// - completion is interrupt low, not-ready clear
// - power-up posts completion interrupt unprompted
// - undriven low-power pin reads high
// - force bits override pin for power mode
// - force bits cleared at power-up
// - high class in low power disables lanes
// - low class stays fully functional in low power
// - management and interrupt work in low power
// - presence output tied low
// - interrupt reports faults, host reads cause
// - interrupt is open-collector, never driven high
// - release interrupt after not-ready and flags read
module lowspeed_device #(
  parameter int unsigned RESET_MIN_CYC = lowspeed_pkg::RESET_MIN_CYC,
  parameter int unsigned INIT_CYC      = lowspeed_pkg::INIT_CYC,
  parameter logic [1:0]  POWER_CLASS   = lowspeed_pkg::POWER_CLASS_RST
) (
  input  wire logic clk,
  input  wire logic resetn,
  lowspeed_if.dev   link,
  input  wire logic fault_event,
  output logic      low_power,
  output logic      lanes_enable
);

  localparam int unsigned RW = $clog2(RESET_MIN_CYC + 2);
  localparam int unsigned IW = $clog2(INIT_CYC + 1);
  localparam logic [RW-1:0] RST_LONG = RW'(RESET_MIN_CYC + 1);
  localparam logic [IW-1:0] INIT_END = IW'(INIT_CYC - 1);

  logic [2:0]                pin_s1_q;
  logic [2:0]                pin_s2_q;
  logic [RW-1:0]             rst_cnt_q;
  logic [IW-1:0]             init_cnt_q;
  lowspeed_pkg::dev_state_t  state_q;
  logic [1:0]                pwr_q;
  logic                      fault_q;
  logic                      int_pend_q;
  logic                      seen_dnr_q;
  logic                      seen_flag_q;
  logic                      ack_q;
  logic [7:0]                rdata_q;
  logic                      low_power_q;
  logic                      lanes_q;

  // pins: 0 select, 1 reset, 2 low power
  wire logic [2:0] pin_raw = {link.low_power_pin, link.module_reset_n,
                              link.module_select_n};

  // idle value high matches the input bias
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire logic selected = ~pin_s2_q[0];
  wire logic rst_pin  = pin_s2_q[1];
  wire logic lp_pin   = pin_s2_q[2];

  // a glitch shorter than the minimum never resets the module
  wire logic in_reset  = ~rst_pin && (rst_cnt_q == RST_LONG);
  wire logic dnr       = (state_q == lowspeed_pkg::DEV_INIT);
  wire logic init_done = (state_q == lowspeed_pkg::DEV_INIT) &&
                         (init_cnt_q == INIT_END) && !in_reset;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_q <= '0;
    end else if (rst_pin) begin
      rst_cnt_q <= '0;
    end else if (rst_cnt_q != RST_LONG) begin
      rst_cnt_q <= rst_cnt_q + RW'(1);
    end
  end

  // held in init while reset low; counting starts on the release edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= lowspeed_pkg::DEV_INIT;
      init_cnt_q <= '0;
    end else if (in_reset) begin
      state_q    <= lowspeed_pkg::DEV_INIT;
      init_cnt_q <= '0;
    end else begin
      case (state_q)
        lowspeed_pkg::DEV_INIT: begin
          if (init_done) begin
            state_q <= lowspeed_pkg::DEV_RUN;
          end else begin
            init_cnt_q <= init_cnt_q + IW'(1);
          end
        end
        lowspeed_pkg::DEV_RUN: begin
          init_cnt_q <= '0;
        end
        default: begin
          state_q <= lowspeed_pkg::DEV_INIT;
        end
      endcase
    end
  end

  // management decode; low power does not gate it
  wire logic access   = link.mgmt_stb && selected;
  wire logic hit_init = (link.mgmt_addr == lowspeed_pkg::INIT_STATUS_OFS);
  wire logic hit_flag = (link.mgmt_addr == lowspeed_pkg::FLAG_FIELD_OFS);
  wire logic hit_pwr  = (link.mgmt_addr == lowspeed_pkg::POWER_CTRL_OFS);
  wire logic hit_ext  = (link.mgmt_addr == lowspeed_pkg::EXT_ID_OFS);
  wire logic rd       = access && !link.mgmt_we;
  wire logic wr_pwr   = access && link.mgmt_we && hit_pwr;
  wire logic rd_flag  = rd && hit_flag;
  wire logic rd_ready = rd && hit_init && !dnr;

  wire logic [7:0] init_byte = 8'(dnr) << lowspeed_pkg::DNR_BIT;
  wire logic [7:0] flag_byte = 8'(fault_q) << lowspeed_pkg::FAULT_BIT;
  wire logic [7:0] pwr_byte  = {6'h00, pwr_q};
  wire logic [7:0] ext_byte  = 8'(POWER_CLASS) <<
                               lowspeed_pkg::POWER_CLASS_LSB;
  wire logic [7:0] rd_byte   = hit_init ? init_byte :
                               hit_flag ? flag_byte :
                               hit_pwr  ? pwr_byte  :
                               hit_ext  ? ext_byte  : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q   <= access;
      rdata_q <= rd ? rd_byte : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr_q <= lowspeed_pkg::POWER_CTRL_RST;
    end else if (in_reset) begin
      pwr_q <= lowspeed_pkg::POWER_CTRL_RST;
    end else if (wr_pwr) begin
      pwr_q <= link.mgmt_wdata[1:0];
    end
  end

  // fault flag: clear on read, a new fault in the same cycle wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_q <= 1'b0;
    end else if (fault_event) begin
      fault_q <= 1'b1;
    end else if (rd_flag || in_reset) begin
      fault_q <= 1'b0;
    end
  end

  // release needs both reads; order between them is free
  wire logic int_set = init_done || fault_event;
  wire logic release_now = int_pend_q && (seen_dnr_q || rd_ready) &&
                           (seen_flag_q || rd_flag);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_pend_q  <= 1'b0;
      seen_dnr_q  <= 1'b0;
      seen_flag_q <= 1'b0;
    end else if (int_set) begin
      int_pend_q  <= 1'b1;
      seen_dnr_q  <= 1'b0;
      seen_flag_q <= 1'b0;
    end else if (release_now || in_reset) begin
      int_pend_q  <= 1'b0;
      seen_dnr_q  <= 1'b0;
      seen_flag_q <= 1'b0;
    end else if (int_pend_q) begin
      seen_dnr_q  <= seen_dnr_q || rd_ready;
      seen_flag_q <= seen_flag_q || rd_flag;
    end
  end

  wire logic force_en  = pwr_q[lowspeed_pkg::FORCE_EN_BIT];
  wire logic force_low = pwr_q[lowspeed_pkg::FORCE_LOW_BIT];
  wire logic lp_mode   = force_en ? force_low : lp_pin;
  wire logic class_high = (POWER_CLASS != 2'h0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_power_q <= 1'b1;
      lanes_q     <= 1'b0;
    end else begin
      low_power_q <= lp_mode;
      lanes_q     <= !(lp_mode && class_high) && !dnr;
    end
  end

  assign low_power           = low_power_q;
  assign lanes_enable        = lanes_q;
  assign link.mgmt_ack       = ack_q;
  assign link.mgmt_rdata     = rdata_q;
  assign link.interrupt_n_o  = 1'b0;
  assign link.interrupt_n_oe = int_pend_q;
  assign link.presence_n_o   = 1'b0;
  assign link.presence_n_oe  = 1'b1;

endmodule : lowspeed_device

// ===== rtl/lowspeed_host.sv
/*
 * Host end of the low-speed control link: software register port that
 * drives select, reset and low-power pins, issues management accesses
 * with select settling waits, and reports interrupt and presence.
 * Assumes interrupt and presence arrive asynchronously from the module.
 */
`timescale 1ns/1ps
module lowspeed_host #(
  parameter int unsigned SEL_ASSERT_CYC   = lowspeed_pkg::SEL_ASSERT_CYC,
  parameter int unsigned SEL_DEASSERT_CYC = lowspeed_pkg::SEL_DEASSERT_CYC,
  parameter int unsigned HOST_RESET_CYC   = lowspeed_pkg::HOST_RESET_CYC,
  parameter int unsigned ACK_WAIT_CYC     = lowspeed_pkg::ACK_WAIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  lowspeed_if.host         link,
  input  wire logic [7:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [31:0] sw_rdata
);

  localparam int unsigned CW = lowspeed_pkg::COUNT_W;

  lowspeed_pkg::host_state_t state_q;
  logic [1:0]    ctrl_q;
  logic [CW-1:0] sel_cnt_q;
  logic [CW-1:0] rst_cnt_q;
  logic [CW-1:0] ack_cnt_q;
  logic [7:0]    cmd_addr_q;
  logic [7:0]    cmd_wdata_q;
  logic          cmd_we_q;
  logic          nack_q;
  logic [7:0]    mrd_q;
  logic          ready_q;
  logic [1:0]    in_s1_q;
  logic [1:0]    in_s2_q;
  logic          stb_q;
  logic          oe_q;
  logic          rst_o_q;
  logic [31:0]   rdata_q;

  wire logic wr_ctrl = sw_wr && (sw_addr == lowspeed_pkg::HOST_CTRL_OFS);
  wire logic wr_cmd  = sw_wr && (sw_addr == lowspeed_pkg::HOST_CMD_OFS);
  wire logic new_sel = sw_wdata[lowspeed_pkg::CTRL_SEL_BIT];
  wire logic sel_chg = wr_ctrl &&
                       (new_sel != ctrl_q[lowspeed_pkg::CTRL_SEL_BIT]);
  wire logic rst_go  = wr_ctrl && sw_wdata[lowspeed_pkg::CTRL_RST_BIT];
  wire logic settled = (sel_cnt_q == '0) && !sel_chg;
  wire logic is_sel  = ctrl_q[lowspeed_pkg::CTRL_SEL_BIT];
  wire logic int_low = ~in_s2_q[0];
  wire logic present = ~in_s2_q[1];

  // interrupt and presence are foreign pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_s1_q <= 2'h3;
      in_s2_q <= 2'h3;
    end else begin
      in_s1_q <= {link.presence_n, link.interrupt_n};
      in_s2_q <= in_s1_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= lowspeed_pkg::HOST_CTRL_RST;
      sel_cnt_q <= '0;
      oe_q      <= 1'b0;
    end else begin
      oe_q <= 1'b1;
      if (wr_ctrl) begin
        ctrl_q <= sw_wdata[1:0];
      end
      if (sel_chg) begin
        sel_cnt_q <= new_sel ? CW'(SEL_ASSERT_CYC)
                             : CW'(SEL_DEASSERT_CYC);
      end else if (sel_cnt_q != '0) begin
        sel_cnt_q <= sel_cnt_q - CW'(1);
      end
    end
  end

  // pulse kept longer than the module's minimum; status void till done
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_q <= '0;
      rst_o_q   <= 1'b1;
      ready_q   <= 1'b0;
    end else begin
      if (rst_go) begin
        rst_cnt_q <= CW'(HOST_RESET_CYC);
      end else if (rst_cnt_q != '0) begin
        rst_cnt_q <= rst_cnt_q - CW'(1);
      end
      rst_o_q <= !(rst_go || rst_cnt_q > CW'(1));
      if (rst_go) begin
        ready_q <= 1'b0;
      end else if (rst_o_q && rst_cnt_q == '0 && int_low) begin
        ready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= lowspeed_pkg::HST_IDLE;
      cmd_addr_q  <= 8'h00;
      cmd_wdata_q <= 8'h00;
      cmd_we_q    <= 1'b0;
      nack_q      <= 1'b0;
      mrd_q       <= 8'h00;
      stb_q       <= 1'b0;
      ack_cnt_q   <= '0;
    end else begin
      stb_q <= 1'b0;
      case (state_q)
        lowspeed_pkg::HST_IDLE: begin
          if (wr_cmd) begin
            cmd_wdata_q <= sw_wdata[7:0];
            cmd_addr_q  <= sw_wdata[15:8];
            cmd_we_q    <= sw_wdata[lowspeed_pkg::CMD_WE_BIT];
            nack_q      <= 1'b0;
            state_q     <= lowspeed_pkg::HST_WAIT;
          end
        end
        lowspeed_pkg::HST_WAIT: begin
          if (!is_sel) begin
            nack_q  <= 1'b1;
            state_q <= lowspeed_pkg::HST_IDLE;
          end else if (settled) begin
            stb_q     <= 1'b1;
            ack_cnt_q <= '0;
            state_q   <= lowspeed_pkg::HST_ACK;
          end
        end
        lowspeed_pkg::HST_ACK: begin
          if (link.mgmt_ack) begin
            mrd_q   <= link.mgmt_rdata;
            state_q <= lowspeed_pkg::HST_IDLE;
          end else if (ack_cnt_q == CW'(ACK_WAIT_CYC)) begin
            nack_q  <= 1'b1;
            state_q <= lowspeed_pkg::HST_IDLE;
          end else begin
            ack_cnt_q <= ack_cnt_q + CW'(1);
          end
        end
        default: begin
          state_q <= lowspeed_pkg::HST_IDLE;
        end
      endcase
    end
  end

  wire logic [31:0] stat_word = {16'h0000, mrd_q, 3'h0,
                                 ready_q, present, int_low && ready_q,
                                 nack_q,
                                 state_q != lowspeed_pkg::HST_IDLE};
  wire logic [31:0] rd_word =
    (sw_addr == lowspeed_pkg::HOST_CTRL_OFS) ? {30'h0, ctrl_q} :
    (sw_addr == lowspeed_pkg::HOST_CMD_OFS)  ?
      {15'h0, cmd_we_q, cmd_addr_q, cmd_wdata_q} :
    (sw_addr == lowspeed_pkg::HOST_STAT_OFS) ? stat_word : 32'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= sw_rd ? rd_word : 32'h0;
    end
  end

  assign sw_rdata        = rdata_q;
  assign link.sel_o      = ~is_sel;
  assign link.sel_oe     = oe_q;
  assign link.rst_o      = rst_o_q;
  assign link.rst_oe     = oe_q;
  assign link.lp_o       = ctrl_q[lowspeed_pkg::CTRL_LP_BIT];
  assign link.lp_oe      = oe_q;
  assign link.mgmt_stb   = stb_q;
  assign link.mgmt_we    = cmd_we_q;
  assign link.mgmt_addr  = cmd_addr_q;
  assign link.mgmt_wdata = cmd_wdata_q;

endmodule : lowspeed_host

// ===== rtl/lowspeed_if.sv
/*
 * Pin-level link between host controller and module: select, reset,
 * low-power, presence, open-drain interrupt, plus an abstract management
 * access channel. Assumes undriven pins resolve through the pull-ups here.
 */
`timescale 1ns/1ps
interface lowspeed_if;
  logic       sel_o;
  logic       sel_oe;
  logic       rst_o;
  logic       rst_oe;
  logic       lp_o;
  logic       lp_oe;
  logic       interrupt_n_o;
  logic       interrupt_n_oe;
  logic       presence_n_o;
  logic       presence_n_oe;
  logic       module_select_n;
  logic       module_reset_n;
  logic       low_power_pin;
  logic       interrupt_n;
  logic       presence_n;
  logic       mgmt_stb;
  logic       mgmt_we;
  logic [7:0] mgmt_addr;
  logic [7:0] mgmt_wdata;
  logic       mgmt_ack;
  logic [7:0] mgmt_rdata;

  // module-side bias / host-side pull-ups on undriven pins
  assign module_select_n = sel_oe ? sel_o : 1'b1;
  assign module_reset_n  = rst_oe ? rst_o : 1'b1;
  assign low_power_pin   = lp_oe ? lp_o : 1'b1;
  assign interrupt_n     = (interrupt_n_oe && !interrupt_n_o) ? 1'b0 : 1'b1;
  assign presence_n      = (presence_n_oe && !presence_n_o) ? 1'b0 : 1'b1;

  modport dev (
    input  module_select_n, module_reset_n, low_power_pin,
    input  mgmt_stb, mgmt_we, mgmt_addr, mgmt_wdata,
    output interrupt_n_o, interrupt_n_oe, presence_n_o, presence_n_oe,
    output mgmt_ack, mgmt_rdata
  );

  modport host (
    output sel_o, sel_oe, rst_o, rst_oe, lp_o, lp_oe,
    output mgmt_stb, mgmt_we, mgmt_addr, mgmt_wdata,
    input  interrupt_n, presence_n, mgmt_ack, mgmt_rdata
  );
endinterface : lowspeed_if

// ===== rtl/lowspeed_pkg.sv
/*
 * Shared constants for the pluggable-module low-speed control pins:
 * management byte map, field positions, reset values, cycle counts,
 * state encodings. Assumes a single 125 MHz clock on both ends.
 */
package lowspeed_pkg;

  localparam int unsigned COUNT_W = 16;

  // management byte map of the module
  localparam logic [7:0] INIT_STATUS_OFS = 8'h02;
  localparam logic [7:0] FLAG_FIELD_OFS  = 8'h03;
  localparam logic [7:0] POWER_CTRL_OFS  = 8'h5d;
  localparam logic [7:0] EXT_ID_OFS      = 8'h81;

  localparam int unsigned DNR_BIT         = 0;
  localparam int unsigned FAULT_BIT       = 0;
  localparam int unsigned FORCE_EN_BIT    = 0;
  localparam int unsigned FORCE_LOW_BIT   = 1;
  localparam int unsigned POWER_CLASS_LSB = 6;

  localparam logic [1:0] POWER_CTRL_RST  = 2'h0;
  localparam logic [1:0] POWER_CLASS_RST = 2'h1;

  // timing counts in clk cycles, plain defaults
  localparam int unsigned RESET_MIN_CYC    = 16;
  localparam int unsigned INIT_CYC         = 64;
  localparam int unsigned SEL_ASSERT_CYC   = 8;
  localparam int unsigned SEL_DEASSERT_CYC = 8;
  localparam int unsigned HOST_RESET_CYC   = 32;
  localparam int unsigned ACK_WAIT_CYC     = 4;

  // controller register map, 32-bit words
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_CMD_OFS  = 8'h04;
  localparam logic [7:0] HOST_STAT_OFS = 8'h08;

  localparam int unsigned CTRL_SEL_BIT   = 0;
  localparam int unsigned CTRL_LP_BIT    = 1;
  localparam int unsigned CTRL_RST_BIT   = 2;
  localparam int unsigned CMD_WE_BIT     = 16;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_NACK_BIT  = 1;
  localparam int unsigned STAT_INT_BIT   = 2;
  localparam int unsigned STAT_PRS_BIT   = 3;
  localparam int unsigned STAT_READY_BIT = 4;
  localparam logic [1:0]  HOST_CTRL_RST  = 2'h0;

  typedef enum logic [1:0] {
    DEV_INIT = 2'b00,
    DEV_RUN  = 2'b01
  } dev_state_t;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_WAIT = 2'b01,
    HST_ACK  = 2'b11
  } host_state_t;

endpackage : lowspeed_pkg

// ===== verification/lowspeed_assertions.sv
/*
 * Checker for the low-speed pin link: presence, open-drain interrupt,
 * management answers and reset completion timing.
 * Assumes one clock and the resolved pins of the link interface.
 */
`timescale 1ns/1ps
module lowspeed_assertions #(
  parameter int unsigned RESET_MIN_CYC = 2,
  parameter int unsigned INIT_CYC      = 4,
  parameter logic [1:0]  POWER_CLASS   = 2'h1
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       module_select_n,
  input wire logic       module_reset_n,
  input wire logic       interrupt_n,
  input wire logic       interrupt_n_o,
  input wire logic       presence_n,
  input wire logic       mgmt_stb,
  input wire logic       mgmt_we,
  input wire logic [7:0] mgmt_addr,
  input wire logic       mgmt_ack,
  input wire logic [7:0] mgmt_rdata
);
  localparam int LONG_LOW = RESET_MIN_CYC + 4;
  localparam int INIT_END = INIT_CYC + 1;
  localparam int INIT_OUT = INIT_CYC + 8;
  logic [7:0] low_q;
  logic [7:0] since_q;
  logic       long_q;

  // start at 4 after power-up: no synchroniser delay on that path
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_q   <= 8'h00;
      since_q <= 8'h04;
      long_q  <= 1'b1;
    end else if (!module_reset_n) begin
      low_q   <= low_q + {7'h0, low_q != 8'hff};
      since_q <= 8'h00;
    end else begin
      if (low_q != 8'h00)
        long_q <= (int'(low_q) >= LONG_LOW);
      low_q   <= 8'h00;
      since_q <= since_q + {7'h0, since_q != 8'hff};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  presence_tied_a: assert property (presence_n == 1'b0)
    else $error("presence pin not low");
  intr_open_drain_a: assert property (interrupt_n_o == 1'b0)
    else $error("interrupt driven high");
  sel_answer_a: assert property (mgmt_stb && !module_select_n
    && !$past(module_select_n) && !$past(module_select_n, 2) |=> mgmt_ack)
    else $error("selected access not answered");
  desel_silent_a: assert property (mgmt_stb && module_select_n
    && $past(module_select_n) && $past(module_select_n, 2) |=> !mgmt_ack)
    else $error("deselected access answered");
  class_field_a: assert property (mgmt_ack && !$past(mgmt_we)
    && $past(mgmt_addr) == lowspeed_pkg::EXT_ID_OFS
    |-> mgmt_rdata[7:6] == POWER_CLASS)
    else $error("power class field wrong");
  init_wait_a: assert property (long_q && int'(since_q) >= 4
    && int'(since_q) <= INIT_END |-> interrupt_n)
    else $error("completion before init interval");
  init_done_a: assert property (long_q
    && int'(since_q) == INIT_OUT |-> !interrupt_n)
    else $error("no completion interrupt");
  // release lands on the edge that takes the read, so its ack shows
  // in the same cycle as the rise
  intr_release_a: assert property ($rose(interrupt_n)
    && since_q > 8'h08 |-> mgmt_ack && !$past(mgmt_we))
    else $error("interrupt released without reads");

  cover property (mgmt_ack);
  cover property (mgmt_stb && module_select_n);
  cover property ($rose(interrupt_n) && since_q > 8'h08);
endmodule : lowspeed_assertions

// ===== verification/module_lowspeed_control_tb.sv
/*
 * Bench for host and module ends joined by the link interface: power-up,
 * select gating, power mode table, module reset, fault interrupt.
 * Assumes the host register map and strobe timing of the package.
 */
`timescale 1ns/1ps
module module_lowspeed_control_tb;
  localparam logic [1:0] PCLS = 2'h2;
  localparam int unsigned RST_MIN  = 2;
  localparam int unsigned INIT_LEN = 4;
  localparam logic [7:0] CTL  = lowspeed_pkg::HOST_CTRL_OFS;
  localparam logic [7:0] STA  = lowspeed_pkg::HOST_STAT_OFS;
  localparam logic [7:0] PWR  = lowspeed_pkg::POWER_CTRL_OFS;
  localparam logic [7:0] FLG  = lowspeed_pkg::FLAG_FIELD_OFS;
  localparam logic [7:0] INI  = lowspeed_pkg::INIT_STATUS_OFS;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic        fault_event = 1'b0;
  logic        low_power;
  logic        lanes_enable;
  logic [31:0] rd_q;
  logic [7:0]  mbyte;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;

  lowspeed_if link ();
  lowspeed_device #(.RESET_MIN_CYC(RST_MIN), .INIT_CYC(INIT_LEN),
    .POWER_CLASS(PCLS))
    u_lowspeed_device (.clk(clk), .resetn(resetn), .link(link),
    .fault_event(fault_event), .low_power(low_power),
    .lanes_enable(lanes_enable));
  lowspeed_host #(.SEL_ASSERT_CYC(2), .SEL_DEASSERT_CYC(2),
    .HOST_RESET_CYC(8), .ACK_WAIT_CYC(4)) u_lowspeed_host (.clk(clk),
    .resetn(resetn), .link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  lowspeed_assertions #(.RESET_MIN_CYC(RST_MIN), .INIT_CYC(INIT_LEN),
    .POWER_CLASS(PCLS))
    u_lowspeed_assertions (.clk(clk), .resetn(resetn),
    .module_select_n(link.module_select_n),
    .module_reset_n(link.module_reset_n), .interrupt_n(link.interrupt_n),
    .interrupt_n_o(link.interrupt_n_o), .presence_n(link.presence_n),
    .mgmt_stb(link.mgmt_stb), .mgmt_we(link.mgmt_we),
    .mgmt_addr(link.mgmt_addr), .mgmt_ack(link.mgmt_ack),
    .mgmt_rdata(link.mgmt_rdata));

  always #4 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("wrong value at %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd   <= 1'b0;
    #1;
    rd_q = sw_rdata;
  endtask : rd

  task automatic poll(input int bit_no, input logic val);
    int n = 0;
    rd(STA);
    while (rd_q[bit_no] !== val && n < 60) begin
      rd(STA);
      n++;
    end
    chk(n < 60, 1'b1, "poll limit");
  endtask : poll

  task automatic mg(input logic we, input logic [7:0] a, input logic [7:0] d);
    wr(lowspeed_pkg::HOST_CMD_OFS, {15'h0, we, a, d});
    poll(lowspeed_pkg::STAT_BUSY_BIT, 1'b0);
    mbyte = rd_q[15:8];
  endtask : mg

  task automatic stat_int(input logic exp, input string msg);
    repeat (4) @(posedge clk);
    rd(STA);
    chk(rd_q[2], exp, msg);
  endtask : stat_int

  task automatic t_powerup();
    poll(lowspeed_pkg::STAT_READY_BIT, 1'b1);
    chk(rd_q[4:2], 3'b111, "power-up status");
    chk(link.presence_n, 1'b0, "presence");
    $display("power-up test done");
  endtask : t_powerup

  task automatic t_select();
    mg(1'b0, lowspeed_pkg::EXT_ID_OFS, 8'h00);
    chk(rd_q[1], 1'b1, "deselected nack");
    wr(CTL, 32'h1);
    mg(1'b0, lowspeed_pkg::EXT_ID_OFS, 8'h00);
    chk(rd_q[1], 1'b0, "selected nack");
    chk(mbyte[7:6], PCLS, "power class");
    rd(8'h40);
    chk(rd_q, 32'h0, "unmapped read");
    $display("select test done");
  endtask : t_select

  task automatic t_power();
    logic exp;
    for (int i = 0; i < 8; i++) begin
      mg(1'b1, PWR, {6'h0, i[2], i[1]});
      wr(CTL, {30'h0, i[0], 1'b1});
      repeat (6) @(posedge clk);
      #1;
      exp = i[1] ? i[2] : i[0];
      chk(low_power, exp, "power mode");
      chk(lanes_enable, !exp, "lanes");
      mg(1'b0, PWR, 8'h00);
      chk(mbyte[1:0], {i[2], i[1]}, "force bits");
    end
    $display("power test done");
  endtask : t_power

  task automatic t_reset();
    wr(CTL, 32'h5);
    poll(lowspeed_pkg::STAT_READY_BIT, 1'b1);
    chk(rd_q[4:2], 3'b111, "reset done");
    mg(1'b0, PWR, 8'h00);
    chk(mbyte[1:0], 2'h0, "force cleared");
    chk(low_power, 1'b0, "pin decides");
    mg(1'b0, INI, 8'h00);
    chk(mbyte[0], 1'b0, "data ready");
    stat_int(1'b1, "int held");
    mg(1'b0, FLG, 8'h00);
    stat_int(1'b0, "int released");
    $display("reset test done");
  endtask : t_reset

  task automatic t_fault();
    @(posedge clk);
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    stat_int(1'b1, "fault int");
    mg(1'b0, FLG, 8'h00);
    chk(mbyte[0], 1'b1, "fault flag");
    mg(1'b0, INI, 8'h00);
    stat_int(1'b0, "fault int released");
    mg(1'b0, FLG, 8'h00);
    chk(mbyte[0], 1'b0, "flag cleared");
    $display("fault test done");
  endtask : t_fault

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_powerup();
    t_select();
    t_power();
    t_reset();
    t_fault();
    end_of_test();
  end
endmodule : module_lowspeed_control_tb
